// ==== dv/cft_checker.sv ====
// Purpose: Concurrent checks on the task-file link and drive-side strobes.
// Assumes: One clock; rst_n asynchronous, active low.
// Notes: Instantiated beside the interface; it watches, it never drives.
`timescale 1ns/10ps
`default_nettype none
module cft_checker
  import cft_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Task-file link
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write,
  input wire logic read,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Cache and media
  input wire logic flushReq,
  input wire logic cacheClean,
  input wire logic writeReq,
  input wire logic writeAck,
  input wire logic [27:0] writeLba
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Idle check keeps a dropped write from being taken for a start
  sequence flushCmd;
    write && addr == TF_CMD && !flushReq && !writeReq &&
      (wdata == CMD_FLUSH || wdata == CMD_FLUSH_EXT);
  endsequence
  sequence pollDirty;
    read && addr == TF_CMD && flushReq && !cacheClean ##1 rvalid;
  endsequence
  a_read_answer: assert property (read |=> rvalid)
    else $error("read strobe not answered next cycle");
  a_rdata_quiet: assert property (!rvalid |-> rdata == 8'h00)
    else $error("read data not zero outside answer");
  a_flush_start: assert property (flushCmd |=> flushReq)
    else $error("flush command did not start a flush");
  a_flush_busy: assert property (pollDirty |-> rdata[ST_BUSY])
    else $error("status not busy while cache dirty");
  a_flush_hold: assert property (flushReq && !cacheClean |=> flushReq)
    else $error("flush ended before cache clean");
  a_flush_release: assert property (flushReq && cacheClean |=> !flushReq)
    else $error("flush request stayed after cache clean");
  a_status_clean: assert property (
    rvalid && $past(addr) == TF_CMD |-> rdata[5] == 1'b0 && rdata[2:1] == 2'b00)
    else $error("fault, corrected or index bit set in status");
  a_error_bits: assert property (
    rvalid && $past(addr) == TF_ERR |-> (rdata & 8'hEB) == 8'h00)
    else $error("error register holds a forbidden bit");
  a_media_hold: assert property (
    writeReq && !writeAck |=> writeReq && $stable(writeLba))
    else $error("sector write request not held until ack");
  a_media_drop: assert property (writeReq && writeAck |=> !writeReq)
    else $error("sector write request not dropped after ack");
  a_host_waits: assert property (flushReq || writeReq |-> !write)
    else $error("task-file write while command busy");
endmodule
`default_nettype wire

// ==== dv/test_cache_flush_track_format_cmds.sv ====
// Purpose: Self-checking bench for controller and drive ends together.
// Assumes: Four sectors a track and six heads to keep tracks short.
// Notes: Cache and media are simple models; media acks each write.
`timescale 1ns/10ps
`default_nettype none
module test_cache_flush_track_format_cmds
  import cft_pkg::*;
;
  localparam int SPT = 4;
  localparam int NHEADS = 6;
  logic clk, rst_n, irq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic cacheClean, writeAck, badSector, flushReq, writeReq;
  logic [27:0] writeLba, badLba;
  logic [27:0] lbaLog[$];
  int badCount, nCompared;
  cft_if tfBus();
  cft_device #(.SECTORS_PER_TRACK(SPT), .HEADS(NHEADS)) i_cft_device (
    .clk(clk), .rst_n(rst_n), .tf(tfBus), .flushReq(flushReq),
    .cacheClean(cacheClean), .writeReq(writeReq), .writeLba(writeLba),
    .writeAck(writeAck), .badSector(badSector));
  cft_host i_cft_host (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .tf(tfBus));
  cft_checker i_cft_checker (
    .clk(clk), .rst_n(rst_n), .addr(tfBus.addr), .wdata(tfBus.wdata),
    .write(tfBus.write), .read(tfBus.read), .rdata(tfBus.rdata),
    .rvalid(tfBus.rvalid), .flushReq(flushReq), .cacheClean(cacheClean),
    .writeReq(writeReq), .writeAck(writeAck), .writeLba(writeLba));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Media: one ack per request, logging every sector actually written
  assign badSector = (writeLba == badLba);
  always @(posedge clk) begin
    writeAck <= writeReq && !writeAck;
    if (writeReq && writeAck)
      lbaLog.push_back(writeLba);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axiWr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic axiRd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask
  // Polling is unbounded here; the watchdog cuts a hang short
  task automatic waitIdle(output logic [31:0] st);
    do axiRd(REG_STATUS, st); while (st[16] !== 1'b0);
  endtask
  task automatic issue(input logic [7:0] c, input logic [27:0] a,
      input logic lMode);
    axiWr(REG_CMD, {24'h0, c});
    axiWr(REG_ADDR, {4'h0, a});
    axiWr(REG_CTRL, {30'h0, 1'b1, lMode});
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    badCount++;
    results();
  end
  initial begin
    logic [31:0] d;
    logic [7:0] c;
    rst_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready} = '0;
    wstrb = 4'hF;
    cacheClean = 1'b1;
    badLba = 28'hFFFFFFF;
    badCount = 0;
    nCompared = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    axiRd(REG_MASK, d);
    chk(d, 32'h0);
    axiWr(REG_MASK, 32'h3);
    axiRd(REG_MASK, d);
    chk(d, 32'h3);
    axiRd(5'h1C, d);
    chk({resp, d[29:0]}, 32'h80000000);
    axiWr(5'h1C, 32'h1);
    chk({30'h0, resp}, 32'h2);
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      c = i ? CMD_FLUSH_EXT : CMD_FLUSH;
      cacheClean <= 1'b0;
      issue(c, 28'h0, 1'b0);
      repeat (20) @(posedge clk);
      axiRd(REG_STATUS, d);
      chk({31'h0, d[16]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      axiWr(REG_CMD, 32'h50);
      axiRd(REG_CMD, d);
      chk(d, {24'h0, c});
      cacheClean <= 1'b1;
      waitIdle(d);
      chk(d, {24'h0, STAT_GOOD});
      chk({31'h0, irq}, 32'h1);
      axiRd(REG_IRQ, d);
      chk(d, 32'h1);
      axiRd(REG_IRQ, d);
      chk(d, 32'h0);
    end
    $display("flush test done");
    badLba <= 28'h0123455;
    lbaLog.delete();
    issue(CMD_FMT_TRACK, 28'h0123456, 1'b1);
    waitIdle(d);
    chk(d, 32'h50);
    chk(32'(lbaLog.size()), 32'h3);
    chk({4'h0, lbaLog[0]}, 32'h0123454);
    chk({4'h0, lbaLog[1]}, 32'h0123456);
    chk({4'h0, lbaLog[2]}, 32'h0123457);
    axiRd(REG_RESULT, d);
    chk(d, 32'h0123457);
    axiRd(REG_ADDR, d);
    chk(d, 32'h0123456);
    axiRd(REG_CTRL, d);
    chk(d, 32'h1);
    axiRd(REG_IRQ, d);
    chk(d, 32'h1);
    badLba <= 28'hFFFFFFF;
    lbaLog.delete();
    issue(CMD_FMT_TRACK, 28'h3000200, 1'b0);
    waitIdle(d);
    chk(d, 32'h50);
    chk(32'(lbaLog.size()), 32'h4);
    chk({4'h0, lbaLog[0]}, 32'h3C);
    chk({4'h0, lbaLog[3]}, 32'h3F);
    lbaLog.delete();
    issue(CMD_FMT_TRACK, 28'h7000200, 1'b0);
    waitIdle(d);
    chk(d, 32'h1451);
    chk(32'(lbaLog.size()), 32'h0);
    axiRd(REG_IRQ, d);
    chk(d, 32'h3);
    $display("format test done");
    axiWr(REG_MASK, 32'h0);
    issue(8'h99, 28'h0, 1'b0);
    waitIdle(d);
    chk(d, 32'h0451);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    axiRd(REG_IRQ, d);
    chk(d, 32'h3);
    $display("abort and mask test done");
    // A clean flush after an error must raise only the done bit
    axiWr(REG_MASK, 32'h3);
    issue(CMD_FLUSH, 28'h0, 1'b0);
    waitIdle(d);
    chk(d, {24'h0, STAT_GOOD});
    axiRd(REG_IRQ, d);
    chk(d, 32'h1);
    $display("flush after error test done");
    results();
  end
endmodule
`default_nettype wire

// ==== rtl/cft_device.sv ====
// Purpose: Drive-side interpreter for flush, extended flush, track format.
// Assumes: Cache and media logic share clk; tf strobes are single-cycle.
// Notes: Status reads answer one cycle after the read strobe.
// How it works
// - E7h starts writing cached data to media
// - Flush completes 50h only after media written
// - EAh flushes too, good status after media
// - Flush errors only aborted; busy,fault,cor,idx clear
// - 50h formats one track, old data lost
// - Format writes zeros to every good sector
// - No read-back verify; done after writes
// - L=0: cylinder in high/mid, head field
// - L=1: 28-bit block address across registers
// - L=1: return current block address afterwards
// - L=1: format whole track holding address
// - Format may report missing-ID and aborted
`timescale 1ns/10ps
`default_nettype none
module cft_device
  import cft_pkg::*;
#(
  parameter int SECTORS_PER_TRACK = 63,
  parameter int HEADS = 16,
  parameter logic [27:0] MAX_LBA = 28'hFFFFFFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Task-file port
  cft_if.dev tf,
  // Write cache
  output logic flushReq,
  input wire logic cacheClean,
  // Media sector writer, zero-filled
  output logic writeReq,
  output logic [27:0] writeLba,
  input wire logic writeAck,
  input wire logic badSector
);
  localparam logic [27:0] SPT = 28'(SECTORS_PER_TRACK);
  localparam logic [27:0] HD = 28'(HEADS);

  if (SECTORS_PER_TRACK < 1 || HEADS < 1 || HEADS > 16) begin : g_chk
    $error("cft_device: geometry out of range");
  end

  function automatic logic [27:0] trackBase(input logic lbaMode,
                                            input logic [27:0] a);
    logic [27:0] cyl;
    cyl = {12'h000, a[23:8]};
    if (lbaMode) begin
      trackBase = a - (a % SPT);
    end else begin
      trackBase = 28'((cyl * HD + {24'h000000, a[27:24]}) * SPT);
    end
  endfunction

  cft_dstate_t state;
  logic [7:0] lowReg;
  logic [7:0] midReg;
  logic [7:0] highReg;
  logic [7:0] devReg;
  logic [7:0] errReg;
  logic [7:0] statReg;
  logic [27:0] left;
  logic lbaMode;

  // Decoding
  wire idle = (state == DS_IDLE);
  // Writes while busy are dropped; the host is expected to poll first.
  wire regWrite = tf.write && idle;
  wire cmdWrite = regWrite && (tf.addr == TF_CMD);
  wire isFlush = (tf.wdata == CMD_FLUSH) || (tf.wdata == CMD_FLUSH_EXT);
  wire isFmt = (tf.wdata == CMD_FMT_TRACK);
  wire [27:0] reqAddr = {devReg[3:0], highReg, midReg, lowReg};
  wire reqL = devReg[DEV_L];
  wire [27:0] base = trackBase(reqL, reqAddr);
  wire headBad = !reqL && ({28'h0000000 | reqAddr[27:24]} >= HD);
  wire rangeBad = headBad || (base > MAX_LBA) ||
                  ((base + SPT - 28'h0000001) > MAX_LBA);
  wire lastSector = (left == 28'h0000001);
  wire stepDone = (state == DS_FMT && badSector) ||
                  (state == DS_WAIT && writeAck);
  wire [7:0] goodStat = STAT_GOOD;
  wire [7:0] errStat = STAT_GOOD | 8'h01;
  wire [7:0] readMux =
    (tf.addr == TF_ERR) ? errReg :
    (tf.addr == TF_LOW) ? lowReg :
    (tf.addr == TF_MID) ? midReg :
    (tf.addr == TF_HIGH) ? highReg :
    (tf.addr == TF_DEV) ? devReg :
    (tf.addr == TF_CMD) ? statReg : 8'h00;

  // Command state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DS_IDLE;
      left <= 28'h0000000;
      lbaMode <= 1'b0;
      flushReq <= 1'b0;
      writeReq <= 1'b0;
      writeLba <= 28'h0000000;
      errReg <= 8'h00;
      statReg <= STAT_RESET;
    end else begin
      unique case (state)
        DS_IDLE: begin
          if (cmdWrite && isFlush) begin
            state <= DS_FLUSH;
            flushReq <= 1'b1;
            errReg <= 8'h00;
            statReg <= 8'h80;
          end else if (cmdWrite && isFmt && rangeBad) begin
            errReg <= 8'h14;
            statReg <= errStat;
          end else if (cmdWrite && isFmt) begin
            state <= DS_FMT;
            lbaMode <= reqL;
            writeLba <= base;
            left <= SPT;
            errReg <= 8'h00;
            statReg <= 8'h80;
          end else if (cmdWrite) begin
            errReg <= 8'h04;
            statReg <= errStat;
          end
        end
        DS_FLUSH: begin
          // Clean means every buffered write is on the media.
          if (cacheClean) begin
            state <= DS_IDLE;
            flushReq <= 1'b0;
            statReg <= goodStat;
          end
        end
        DS_FMT: begin
          // Defective sectors are passed over rather than written.
          if (!badSector) begin
            writeReq <= 1'b1;
            state <= DS_WAIT;
          end
        end
        DS_WAIT: begin
          if (writeAck) begin
            writeReq <= 1'b0;
            state <= DS_FMT;
          end
        end
      endcase
      if (stepDone) begin
        if (lastSector) begin
          state <= DS_IDLE;
          statReg <= goodStat;
        end else begin
          writeLba <= writeLba + 28'h0000001;
          left <= left - 28'h0000001;
        end
      end
    end
  end

  // Task-file registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowReg <= 8'h00;
      midReg <= 8'h00;
      highReg <= 8'h00;
      devReg <= DEV_RESET;
    end else if (stepDone && lastSector && lbaMode) begin
      lowReg <= writeLba[7:0];
      midReg <= writeLba[15:8];
      highReg <= writeLba[23:16];
      devReg <= {devReg[7:4], writeLba[27:24]};
    end else if (regWrite) begin
      if (tf.addr == TF_LOW) begin
        lowReg <= tf.wdata;
      end
      if (tf.addr == TF_MID) begin
        midReg <= tf.wdata;
      end
      if (tf.addr == TF_HIGH) begin
        highReg <= tf.wdata;
      end
      if (tf.addr == TF_DEV) begin
        devReg <= tf.wdata;
      end
    end
  end

  // Read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tf.rdata <= 8'h00;
      tf.rvalid <= 1'b0;
    end else begin
      tf.rvalid <= tf.read;
      tf.rdata <= tf.read ? readMux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/cft_host.sv ====
// Purpose: Controller end: AXI4-Lite registers drive task-file sequences.
// Assumes: Software waits for REG_STATUS busy clear before a new go.
// Notes: Polls status until busy clears, then collects results.
`timescale 1ns/10ps
`default_nettype none
module cft_host
  import cft_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Task-file port
  cft_if.host tf
);
  cft_hstate_t state;
  logic [3:0] step;
  logic [7:0] cmdReg;
  logic [27:0] addrReg;
  logic lMode;
  logic [7:0] statSeen;
  logic [7:0] errSeen;
  logic [27:0] result;
  logic [1:0] irqStat;
  logic [1:0] irqMask;

  // Decoding
  wire wrTake = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire busy = (state != HS_IDLE);
  wire goWrite = wrTake && (s_axi_awaddr == REG_CTRL) && s_axi_wstrb[0] &&
                 s_axi_wdata[CTRL_GO] && !busy;
  wire fmtCmd = (cmdReg == CMD_FMT_TRACK);
  wire [7:0] stepData =
    (step == 4'h0) ? addrReg[7:0] : (step == 4'h1) ? addrReg[15:8] :
    (step == 4'h2) ? addrReg[23:16] :
    (step == 4'h3) ? {1'b1, lMode, 2'b10, addrReg[27:24]} : cmdReg;
  wire [2:0] stepAddr =
    (step == 4'h0 || step == 4'h7) ? TF_LOW :
    (step == 4'h1 || step == 4'h8) ? TF_MID :
    (step == 4'h2 || step == 4'h9) ? TF_HIGH :
    (step == 4'h3 || step == STEP_LAST) ? TF_DEV :
    (step == STEP_ERR) ? TF_ERR : TF_CMD;
  wire finish = state == HS_WAIT && tf.rvalid &&
                ((step == STEP_ERR && !(fmtCmd && lMode)) ||
                 step == STEP_LAST);
  wire rdMapped = s_axi_araddr <= REG_MASK && s_axi_araddr[1:0] == 2'b00;
  wire wrMapped = s_axi_awaddr <= REG_MASK && s_axi_awaddr[1:0] == 2'b00;
  wire irqRead = rdTake && (s_axi_araddr == REG_IRQ);
  // On the error read errSeen still holds the previous command's code
  wire errNow = (step == STEP_ERR) ? (tf.rdata != 8'h00) :
                (errSeen != 8'h00);
  wire [1:0] irqSet = {finish && errNow, finish};
  wire [31:0] readMux =
    (s_axi_araddr == REG_CMD) ? {24'h000000, cmdReg} :
    (s_axi_araddr == REG_ADDR) ? {4'h0, addrReg} :
    (s_axi_araddr == REG_CTRL) ? {31'h00000000, lMode} :
    (s_axi_araddr == REG_STATUS) ? {15'h0000, busy, errSeen, statSeen} :
    (s_axi_araddr == REG_RESULT) ? {4'h0, result} :
    (s_axi_araddr == REG_IRQ) ? {30'h00000000, irqStat} :
    (s_axi_araddr == REG_MASK) ? {30'h00000000, irqMask} : 32'h00000000;

  // AXI handshakes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
      if (wrTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rdTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rdMapped ? 2'b00 : 2'b10;
        s_axi_rdata <= readMux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers and interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReg <= 8'h00;
      addrReg <= 28'h0000000;
      lMode <= 1'b0;
      irqMask <= 2'b00;
      irqStat <= 2'b00;
      irq <= 1'b0;
    end else begin
      // Command, address and mode settings are frozen while a command runs.
      if (wrTake && !busy && s_axi_awaddr == REG_CMD && s_axi_wstrb[0]) begin
        cmdReg <= s_axi_wdata[7:0];
      end
      if (wrTake && !busy && s_axi_awaddr == REG_ADDR) begin
        addrReg <= {s_axi_wstrb[3] ? s_axi_wdata[27:24] : addrReg[27:24],
                    s_axi_wstrb[2] ? s_axi_wdata[23:16] : addrReg[23:16],
                    s_axi_wstrb[1] ? s_axi_wdata[15:8] : addrReg[15:8],
                    s_axi_wstrb[0] ? s_axi_wdata[7:0] : addrReg[7:0]};
      end
      if (wrTake && !busy && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]) begin
        lMode <= s_axi_wdata[CTRL_L];
      end
      if (wrTake && s_axi_awaddr == REG_MASK && s_axi_wstrb[0]) begin
        irqMask <= s_axi_wdata[1:0];
      end
      // A new event wins over the clearing read.
      irqStat <= (irqRead ? 2'b00 : irqStat) | irqSet;
      irq <= |(((irqRead ? 2'b00 : irqStat) | irqSet) & irqMask);
    end
  end

  // Task-file sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HS_IDLE;
      step <= 4'h0;
      statSeen <= STAT_RESET;
      errSeen <= 8'h00;
      result <= 28'h0000000;
      tf.addr <= TF_CMD;
      tf.wdata <= 8'h00;
      tf.write <= 1'b0;
      tf.read <= 1'b0;
    end else begin
      tf.write <= 1'b0;
      tf.read <= 1'b0;
      unique case (state)
        HS_IDLE: begin
          if (goWrite) begin
            state <= HS_ISSUE;
            step <= fmtCmd ? 4'h0 : STEP_CMD;
          end
        end
        HS_ISSUE: begin
          tf.addr <= stepAddr;
          tf.wdata <= stepData;
          if (step <= STEP_CMD) begin
            tf.write <= 1'b1;
            step <= step + 4'h1;
          end else begin
            tf.read <= 1'b1;
            state <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (tf.rvalid) begin
            state <= finish ? HS_IDLE : HS_ISSUE;
            if (step == STEP_STAT) begin
              statSeen <= tf.rdata;
              // Nothing else is trusted until busy drops.
              if (!tf.rdata[ST_BUSY]) begin
                step <= STEP_ERR;
              end
            end else begin
              step <= step + 4'h1;
            end
            if (step == STEP_ERR) begin
              errSeen <= tf.rdata;
            end
            if (step == 4'h7) begin
              result[7:0] <= tf.rdata;
            end
            if (step == 4'h8) begin
              result[15:8] <= tf.rdata;
            end
            if (step == 4'h9) begin
              result[23:16] <= tf.rdata;
            end
            if (step == STEP_LAST) begin
              result[27:24] <= tf.rdata[3:0];
            end
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/cft_if.sv ====
// Purpose: Task-file register port between controller and drive.
// Assumes: Both ends on clk; reads answer one cycle later.
// Notes: write and read are one-cycle strobes.
`timescale 1ns/10ps
`default_nettype none
interface cft_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic write;
  logic read;
  logic [7:0] rdata;
  logic rvalid;
  modport dev (input addr, input wdata, input write, input read,
               output rdata, output rvalid);
  modport host (output addr, output wdata, output write, output read,
                input rdata, input rvalid);
endinterface
`default_nettype wire

// ==== rtl/cft_pkg.sv ====
// Purpose: Shared constants for the flush and track-format task-file pair.
// Assumes: 8-bit task-file registers, one shared clock.
// Notes: Host register map is reached over AXI4-Lite.
package cft_pkg;
  // Command codes
  localparam logic [7:0] CMD_FLUSH = 8'hE7;
  localparam logic [7:0] CMD_FLUSH_EXT = 8'hEA;
  localparam logic [7:0] CMD_FMT_TRACK = 8'h50;
  // Completion and reset values
  localparam logic [7:0] STAT_GOOD = 8'h50;
  localparam logic [7:0] STAT_RESET = 8'h50;
  localparam logic [7:0] DEV_RESET = 8'hA0;
  // Status, error and device bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_ERR = 0;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int DEV_L = 6;
  // Task-file register addresses
  localparam logic [2:0] TF_ERR = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_LOW = 3'h3;
  localparam logic [2:0] TF_MID = 3'h4;
  localparam logic [2:0] TF_HIGH = 3'h5;
  localparam logic [2:0] TF_DEV = 3'h6;
  localparam logic [2:0] TF_CMD = 3'h7;
  // Host register byte offsets and bit positions
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_CTRL = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0C;
  localparam logic [4:0] REG_RESULT = 5'h10;
  localparam logic [4:0] REG_IRQ = 5'h14;
  localparam logic [4:0] REG_MASK = 5'h18;
  localparam int CTRL_L = 0;
  localparam int CTRL_GO = 1;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  // Host sequence steps
  localparam logic [3:0] STEP_CMD = 4'h4;
  localparam logic [3:0] STEP_STAT = 4'h5;
  localparam logic [3:0] STEP_ERR = 4'h6;
  localparam logic [3:0] STEP_LAST = 4'hA;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_FLUSH = 2'b01,
    DS_FMT = 2'b10,
    DS_WAIT = 2'b11
  } cft_dstate_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ISSUE = 2'b01,
    HS_WAIT = 2'b10
  } cft_hstate_t;
endpackage
